// file: pkg/slot_keystream_masker_defines.svh
`ifndef SLOT_KEYSTREAM_MASKER_DEFINES_SVH
`define SLOT_KEYSTREAM_MASKER_DEFINES_SVH

// Field layout, as bit positions within one full_slot_field.
`define FIELD_BITS 9'd388
`define HDR_BITS 9'd8
`define TAIL_FIRST 9'd8
`define TAIL_LAST 9'd47
`define PAY_FIRST 9'd64
`define PAY_LAST 9'd383
`define LAST_POS 9'd387
`define PAY_DATA_BITS 9'd320
`define SEG_BITS 9'd360
`define SINGLE_DATA_BITS 9'd304
`define SUB_PERIOD 9'd80
`define SUB_DATA_BITS 9'd64

// Header code positions.
`define HDR_TAIL_LSB 1
`define HDR_PAY_LSB 4
`define TAIL_CT_CODE 3'h6
`define PAY_USER_CODE 3'h0

// Register offsets.
`define REG_CTRL 32'h0000_0000
`define REG_FRAME 32'h0000_0004
`define REG_STATUS 32'h0000_0008

// Control fields and reset values.
`define CTRL_EN_BIT 0
`define CTRL_FIXED_BIT 1
`define CTRL_FMT_LSB 2
`define CTRL_CLEN_LSB 4
`define CTRL_RESET 32'h0000_1400
`define FRAME_MF_LSB 4
`define STAT_BUSY_BIT 0
`define STAT_ERR_BIT 1
`define STAT_SEG_BIT 2

`endif

// file: pkg/slot_keystream_masker_pkg.sv
package slot_keystream_masker_pkg;

  // One bit of a full_slot_field, with the direction it travels (1 = transmit).
  typedef struct packed {
    logic dir;
    logic data;
  } field_bit_s;

  // Payload layout for user-type payloads, chosen by service type.
  typedef enum logic [1:0] {
    FMT_UNPROTECTED,
    FMT_MULTI_CHECK,
    FMT_SINGLE_CHECK,
    FMT_CODED
  } user_fmt_e;

endpackage : slot_keystream_masker_pkg

// file: rtl/slot_keystream_masker.sv
// Implementation choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ns
`include "slot_keystream_masker_defines.svh"
module slot_keystream_masker
  import slot_keystream_masker_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  input wire logic i_frame_start,
  output logic o_kg_init,
  output logic [34:0] o_init_vector,
  input wire logic i_ks_valid,
  input wire logic i_ks_bit,
  output logic o_ks_ready,
  input wire logic i_fb_valid,
  input wire field_bit_s i_fb,
  output logic o_fb_ready,
  output logic o_out_valid,
  output field_bit_s o_out,
  output logic o_out_last,
  input wire logic i_out_ready
);

  // Bus slave state.
  logic wr_pend_ff;
  logic [31:0] wr_addr_ff;
  logic [31:0] hrdata_ff;
  logic [31:0] ctrl_ff;
  logic [3:0] frame_ff;
  logic [23:0] mframe_ff;
  logic order_err_ff;
  logic hreadyout_ff;
  logic hresp_ff;

  // Frame and field state.
  logic frame_cipher_ff;
  logic in_frame_ff;
  logic seg_ff;
  logic [8:0] pos_ff;
  logic [7:0] hdr_ff;
  logic kg_init_ff;
  logic [34:0] iv_ff;

  // One-bit holding stages toward the field and key sources.
  logic fbuf_full_ff;
  field_bit_s fbuf_ff;
  logic kbuf_full_ff;
  logic kbuf_ff;
  logic fb_ready_ff;
  logic ks_ready_ff;
  logic out_valid_ff;
  field_bit_s out_ff;
  logic out_last_ff;

  // Bus decode.
  wire addr_phase = i_hsel && i_htrans[1] && i_hready;
  wire rd_req = addr_phase && !i_hwrite;
  wire wr_req = addr_phase && i_hwrite;
  wire hit_ctrl = (i_haddr == `REG_CTRL);
  wire hit_frame = (i_haddr == `REG_FRAME);
  wire hit_status = (i_haddr == `REG_STATUS);
  wire wr_ctrl = wr_pend_ff && (wr_addr_ff == `REG_CTRL);
  wire wr_frame = wr_pend_ff && (wr_addr_ff == `REG_FRAME);
  wire wr_status = wr_pend_ff && (wr_addr_ff == `REG_STATUS);

  wire cipher_en = ctrl_ff[`CTRL_EN_BIT];
  wire fixed_end = ctrl_ff[`CTRL_FIXED_BIT];
  wire [1:0] fmt_code = ctrl_ff[`CTRL_FMT_LSB +: 2];
  wire user_fmt_e user_fmt = user_fmt_e'(fmt_code);
  wire [8:0] coded_len = ctrl_ff[`CTRL_CLEN_LSB +: 9];

  wire [31:0] status_word = {29'h0, seg_ff, order_err_ff, in_frame_ff};
  wire [31:0] frame_word = {4'h0, mframe_ff, frame_ff};
  // Unmapped offsets read as zero.
  wire [31:0] rd_mux = hit_ctrl ? ctrl_ff :
                       hit_frame ? frame_word :
                       hit_status ? status_word : 32'h0;

  // Frame counting and init vector for the key stream generator.
  wire [3:0] frame_inc = frame_ff + 4'h1;
  wire frame_wrap = (frame_ff == 4'hf);
  wire [23:0] mframe_inc = mframe_ff + 24'h1;
  // The init_vector takes the frame and multiframe numbers as they stand at frame start.
  wire [34:0] iv_now = {7'h0, mframe_ff, frame_ff};

  // Field position classification.
  wire in_hdr = (pos_ff < `HDR_BITS);
  wire in_tail = (pos_ff >= `TAIL_FIRST) && (pos_ff <= `TAIL_LAST);
  wire in_pay = (pos_ff >= `PAY_FIRST) && (pos_ff <= `PAY_LAST);
  wire [8:0] pay_idx = pos_ff - `PAY_FIRST;
  wire field_end = (pos_ff == `LAST_POS);

  // Header decode.
  // Header bit k is the k-th field bit; bits 3:1 give the tail type, 6:4 the payload.
  wire tail_is_ct = (hdr_ff[`HDR_TAIL_LSB +: 3] == `TAIL_CT_CODE);
  wire pay_is_user = (hdr_ff[`HDR_PAY_LSB +: 3] == `PAY_USER_CODE);

  // Data bit masks of each payload layout.
  // Each of the four subfields holds 64 data bits, then its 16-bit subfield_check.
  wire [3:0] sub_hit;
  for (genvar g = 0; g < 4; g++) begin : g_sub
    localparam logic [8:0] SUB_BASE = 9'(g) * `SUB_PERIOD;
    assign sub_hit[g] = (pay_idx >= SUB_BASE) &&
                        (pay_idx < SUB_BASE + `SUB_DATA_BITS);
  end
  wire multi_data = |sub_hit;
  wire single_data = (pay_idx < `SINGLE_DATA_BITS);
  wire unprot_data = (pay_idx < `PAY_DATA_BITS);
  // A coded length above the data width must never reach the parity bits.
  wire coded_data = (pay_idx < coded_len) && unprot_data;

  logic user_data;
  always_comb begin
    unique case (user_fmt)
      FMT_UNPROTECTED: user_data = unprot_data;
      FMT_MULTI_CHECK: user_data = multi_data;
      FMT_SINGLE_CHECK: user_data = single_data;
      FMT_CODED: user_data = coded_data;
    endcase
  end

  // Control and mixed payloads always take the multi-check layout.
  wire pay_data = pay_is_user ? user_data : multi_data;

  // Each tail and payload position owns one key bit in generator order.
  wire key_pos = in_tail || in_pay;
  wire need_key = frame_cipher_ff && key_pos;
  wire apply_key = need_key && (in_tail ? tail_is_ct : pay_data);

  // A bit steps on only with the output free and, in a ciphered frame, if it owns a key bit, the key held.
  wire out_free = !out_valid_ff || i_out_ready;
  wire step = fbuf_full_ff && out_free && (!need_key || kbuf_full_ff);
  wire take_fb = i_fb_valid && fb_ready_ff;
  wire take_ks = i_ks_valid && ks_ready_ff;

  // Segment order per end: fixed transmits on the first, portable receives on it.
  wire expect_dir = fixed_end ^ seg_ff;
  wire dir_bad = step && frame_cipher_ff && (pos_ff == 9'd0) && (fbuf_ff.dir != expect_dir);

  // Ready is registered, so a holding stage refills one cycle after it empties.
  wire nxt_fbuf_full = take_fb || (fbuf_full_ff && !step);
  wire nxt_kbuf_full = take_ks || (kbuf_full_ff && !(step && need_key));

  // XOR is its own inverse, so one path serves both directions.
  field_bit_s nxt_out;
  always_comb begin
    nxt_out.dir = fbuf_ff.dir;
    nxt_out.data = fbuf_ff.data ^ (apply_key & kbuf_ff);
  end

  // The slave never stalls and always answers OKAY; both stay registered outputs.
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end else begin
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end
  end

  // Writes land in the data phase; read data is registered in the address phase.
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 32'h0;
      hrdata_ff <= 32'h0;
    end else begin
      wr_pend_ff <= wr_req;
      if (addr_phase) begin
        wr_addr_ff <= i_haddr;
      end
      if (rd_req) begin
        hrdata_ff <= rd_mux;
      end
    end
  end

  // Bits above the coded length field are not kept and read back as zero.
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_ff <= `CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_ff <= {19'h0, i_hwdata[12:0]};
    end
  end

  // A software write to the frame counter wins over the frame step.
  // The multiframe number advances when the frame number wraps.
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      frame_ff <= 4'h0;
      mframe_ff <= 24'h0;
    end else if (wr_frame) begin
      frame_ff <= i_hwdata[3:0];
      mframe_ff <= i_hwdata[`FRAME_MF_LSB +: 24];
    end else if (i_frame_start) begin
      frame_ff <= frame_inc;
      if (frame_wrap) begin
        mframe_ff <= mframe_inc;
      end
    end
  end

  // A new order fault wins over a clearing write.
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      order_err_ff <= 1'b0;
    end else if (dir_bad) begin
      order_err_ff <= 1'b1;
    end else if (wr_status && i_hwdata[`STAT_ERR_BIT]) begin
      order_err_ff <= 1'b0;
    end
  end

  // Each frame start re-initialises the generator when ciphering is on.
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      kg_init_ff <= 1'b0;
      iv_ff <= 35'h0;
      frame_cipher_ff <= 1'b0;
      in_frame_ff <= 1'b0;
    end else begin
      kg_init_ff <= i_frame_start && cipher_en;
      if (i_frame_start) begin
        iv_ff <= iv_now;
        frame_cipher_ff <= cipher_en;
        in_frame_ff <= 1'b1;
      end else if (step && field_end && seg_ff) begin
        in_frame_ff <= 1'b0;
      end
    end
  end

  // Header bits are kept as they pass so the tail and payload decode can use them.
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pos_ff <= 9'h0;
      seg_ff <= 1'b0;
      hdr_ff <= 8'h0;
    end else if (i_frame_start) begin
      pos_ff <= 9'h0;
      seg_ff <= 1'b0;
    end else if (step) begin
      if (in_hdr) begin
        hdr_ff[pos_ff[2:0]] <= fbuf_ff.data;
      end
      if (field_end) begin
        pos_ff <= 9'h0;
        seg_ff <= ~seg_ff;
      end else begin
        pos_ff <= pos_ff + 9'h1;
      end
    end
  end

  // Each stage holds one bit; ready is the registered inverse of its next fill state.
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      fbuf_full_ff <= 1'b0;
      fbuf_ff <= '0;
      kbuf_full_ff <= 1'b0;
      kbuf_ff <= 1'b0;
      fb_ready_ff <= 1'b0;
      ks_ready_ff <= 1'b0;
    end else begin
      fbuf_full_ff <= nxt_fbuf_full;
      kbuf_full_ff <= nxt_kbuf_full;
      fb_ready_ff <= !nxt_fbuf_full;
      ks_ready_ff <= !nxt_kbuf_full;
      if (take_fb) begin
        fbuf_ff <= i_fb;
      end
      if (take_ks) begin
        kbuf_ff <= i_ks_bit;
      end
    end
  end

  // The output bit stands until the far side takes it.
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      out_valid_ff <= 1'b0;
      out_ff <= '0;
      out_last_ff <= 1'b0;
    end else if (step) begin
      out_valid_ff <= 1'b1;
      out_ff <= nxt_out;
      out_last_ff <= field_end;
    end else if (i_out_ready) begin
      out_valid_ff <= 1'b0;
    end
  end

  assign o_hreadyout = hreadyout_ff;
  assign o_hresp = hresp_ff;
  assign o_hrdata = hrdata_ff;
  assign o_kg_init = kg_init_ff;
  assign o_init_vector = iv_ff;
  assign o_ks_ready = ks_ready_ff;
  assign o_fb_ready = fb_ready_ff;
  assign o_out_valid = out_valid_ff;
  assign o_out = out_ff;
  assign o_out_last = out_last_ff;

endmodule : slot_keystream_masker

// file: tb/slot_keystream_masker_props.sv
`timescale 1ns/1ns
module slot_keystream_masker_props
  import slot_keystream_masker_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_frame_start,
  input wire logic o_kg_init,
  input wire logic [34:0] o_init_vector,
  input wire logic i_ks_valid,
  input wire logic o_ks_ready,
  input wire logic i_fb_valid,
  input wire logic o_fb_ready,
  input wire logic o_out_valid,
  input wire field_bit_s o_out,
  input wire logic o_out_last,
  input wire logic i_out_ready
);
  logic armed_ff;
  logic [9:0] keys_ff;
  logic [9:0] pos_ff;
  wire out_hs = o_out_valid && i_out_ready;
  wire pos_wrap = i_frame_start || (out_hs && pos_ff == 10'h183);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  sequence s_take;
    i_fb_valid && o_fb_ready;
  endsequence
  sequence s_key;
    i_ks_valid && o_ks_ready;
  endsequence
  // Armed marks a frame whose generator was started; keys_ff counts its key bits.
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      armed_ff <= 1'b0;
      keys_ff <= 10'h0;
      pos_ff <= 10'h0;
    end else begin
      armed_ff <= !i_frame_start && (o_kg_init || armed_ff);
      keys_ff <= o_kg_init ? 10'h0 : keys_ff + {9'h0, i_ks_valid && o_ks_ready};
      pos_ff <= pos_wrap ? 10'h0 : pos_ff + {9'h0, out_hs};
    end
  end
  AST_KG_PULSE: assert property (o_kg_init |=> !o_kg_init)
    else $error("init pulse longer than one cycle");
  AST_KG_CAUSE: assert property (o_kg_init |-> $past(i_frame_start))
    else $error("init pulse without frame start");
  AST_IV_HOLD: assert property (!i_frame_start |=> $stable(o_init_vector))
    else $error("init vector changed inside a frame");
  AST_IV_UPPER: assert property (o_init_vector[34:28] == 7'h0)
    else $error("init vector upper bits not zero");
  AST_NO_KEY_CLEAR: assert property (s_key |-> armed_ff)
    else $error("key bit taken in a clear frame");
  AST_KEY_CAP: assert property (keys_ff <= 10'h2d0)
    else $error("more key bits than two segments");
  AST_KEY_ALL: assert property (i_frame_start && armed_ff |-> keys_ff == 10'h2d0)
    else $error("frame ended without both segments consumed");
  AST_OUT_HOLD: assert property (o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out))
    else $error("output bit changed while stalled");
  AST_LAST_POS: assert property (o_out_valid |-> o_out_last == (pos_ff == 10'h183))
    else $error("last flag not on bit 387");
  AST_TAKE_GAP: assert property (s_take |=> !o_fb_ready)
    else $error("field bit accepted while holding stage full");
endmodule : slot_keystream_masker_props

bind slot_keystream_masker slot_keystream_masker_props u_props (
  .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_frame_start(i_frame_start),
  .o_kg_init(o_kg_init), .o_init_vector(o_init_vector), .i_ks_valid(i_ks_valid),
  .o_ks_ready(o_ks_ready), .i_fb_valid(i_fb_valid), .o_fb_ready(o_fb_ready),
  .o_out_valid(o_out_valid), .o_out(o_out), .o_out_last(o_out_last),
  .i_out_ready(i_out_ready)
);

// file: tb/keystream_source_model.sv
`timescale 1ns/1ns
module keystream_source_model #(
  parameter logic [63:0] CIPHER_KEY = 64'h5a3c_96e1_0f87_2d4b
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_kg_init,
  input wire logic [34:0] i_init_vector,
  input wire logic i_ks_ready,
  input wire logic i_slow,
  output logic o_ks_valid,
  output logic o_ks_bit
);
  logic [63:0] lfsr_ff;
  logic [9:0] left_ff;
  wire [63:0] nxt_lfsr = {lfsr_ff[62:0], ^{lfsr_ff[63], lfsr_ff[62], lfsr_ff[60], lfsr_ff[59]}};
  // An idle bit line flips every cycle so a stale key bit is never mistaken for data.
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      lfsr_ff <= 64'h1;
      left_ff <= 10'h0;
      o_ks_valid <= 1'b0;
      o_ks_bit <= 1'b0;
    end else if (i_kg_init) begin
      lfsr_ff <= CIPHER_KEY ^ {29'h0, i_init_vector};
      left_ff <= 10'h2d0;
      o_ks_valid <= 1'b0;
    end else if (o_ks_valid && !i_ks_ready) begin
      o_ks_valid <= 1'b1;
    end else if (left_ff != 10'h0 && !(i_slow && $urandom_range(1))) begin
      o_ks_valid <= 1'b1;
      o_ks_bit <= lfsr_ff[63];
      lfsr_ff <= nxt_lfsr;
      left_ff <= left_ff - 10'h1;
    end else begin
      o_ks_valid <= 1'b0;
      o_ks_bit <= ~o_ks_bit;
    end
  end
endmodule : keystream_source_model

// file: tb/tb_top.sv
`timescale 1ns/1ns
module tb_top
  import slot_keystream_masker_pkg::*;
;
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0, frame_start = 1'b0, fb_valid = 1'b0;
  logic out_ready = 1'b0, slow = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
  field_bit_s fb = '0;
  field_bit_s out;
  field_bit_s inb [776];
  logic ks [720];
  logic hready, hresp, kg_init, ks_valid, ks_bit, ks_ready, fb_ready, out_valid, out_last;
  logic [34:0] iv;
  logic ciph;
  logic [1:0] ufmt;
  logic [27:0] fcnt;
  int icnt, kcnt, ocnt, clen, n_errors, total_checks;
  always #10 i_clock = ~i_clock;
  slot_keystream_masker dut (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
    .i_frame_start(frame_start), .o_kg_init(kg_init), .o_init_vector(iv),
    .i_ks_valid(ks_valid), .i_ks_bit(ks_bit), .o_ks_ready(ks_ready), .i_fb_valid(fb_valid),
    .i_fb(fb), .o_fb_ready(fb_ready), .o_out_valid(out_valid), .o_out(out),
    .o_out_last(out_last), .i_out_ready(out_ready)
  );
  keystream_source_model keystream_generator (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_kg_init(kg_init), .i_init_vector(iv),
    .i_ks_ready(ks_ready), .i_slow(slow), .o_ks_valid(ks_valid), .o_ks_bit(ks_bit)
  );
  function automatic logic mapped(int p, logic [2:0] tt, logic [2:0] pt, logic [1:0] fm, int cl);
    int b;
    b = p - 64;
    if (p >= 8 && p <= 47) return tt == 3'h6;
    if (p < 64 || p > 383) return 1'b0;
    if (pt != 3'h0 || fm == FMT_MULTI_CHECK) return b % 80 < 64;
    if (fm == FMT_SINGLE_CHECK) return b < 304;
    if (fm == FMT_CODED) return b < cl;
    return 1'b1;
  endfunction : mapped
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge i_clock); while (!hready);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge i_clock); while (!hready);
    rd = hrdata;
  endtask : bus
  task automatic check_out();
    int p, f, k;
    field_bit_s e;
    logic [2:0] tt, pt;
    p = ocnt % 388;
    f = ocnt / 388;
    e = inb[ocnt];
    tt = {inb[f*388+3].data, inb[f*388+2].data, inb[f*388+1].data};
    pt = {inb[f*388+6].data, inb[f*388+5].data, inb[f*388+4].data};
    k = f * 360 + (p < 48 ? p - 8 : p - 24);
    if (ciph && mapped(p, tt, pt, ufmt, clen)) e.data = e.data ^ ks[k];
    chk({out, out_last}, {e, p == 387});
    ocnt++;
  endtask : check_out
  always @(posedge i_clock) begin
    if (fb_valid && fb_ready) begin
      inb[icnt] = fb;
      icnt++;
    end
    if (ks_valid && ks_ready) begin
      ks[kcnt] = ks_bit;
      kcnt++;
    end
    if (out_valid && out_ready) check_out();
    out_ready <= $urandom_range(3) != 0;
  end
  task automatic send(input logic [387:0] f, input logic d);
    for (int i = 0; i < 388; i++) begin
      fb_valid <= 1'b1;
      fb <= '{dir: d, data: f[i]};
      do @(posedge i_clock); while (!fb_ready);
    end
  endtask : send
  task automatic frame(input logic en, input logic fix, input logic [1:0] fm,
                       input logic [2:0] tt, input logic [2:0] pt, input logic bad);
    logic [387:0] fld [2];
    int w;
    clen = $urandom_range(320);
    for (int j = 0; j < 2; j++) begin
      for (int i = 0; i < 388; i++) fld[j][i] = $urandom_range(1);
      fld[j][3:1] = tt;
      fld[j][6:4] = pt;
    end
    bus(1'b1, 32'h0, {19'h0, clen[8:0], fm, fix, en});
    ciph = en;
    ufmt = fm;
    icnt = 0;
    kcnt = 0;
    ocnt = 0;
    slow <= $urandom_range(1);
    frame_start <= 1'b1;
    @(posedge i_clock);
    frame_start <= 1'b0;
    #1;
    chk(kg_init, en);
    chk(iv, {7'h0, fcnt});
    fcnt++;
    @(posedge i_clock);
    send(fld[0], fix ^ bad);
    send(fld[1], !(fix ^ bad));
    fb_valid <= 1'b0;
    for (w = 0; w < 8000 && ocnt < 776; w++) @(posedge i_clock);
    chk(ocnt, 776);
    chk(kcnt, en ? 720 : 0);
    $display("frame test done");
  endtask : frame
  initial begin
    void'($urandom(32'hd381d56d));
    repeat (6) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    @(posedge i_clock);
    bus(1'b0, 32'h0, 32'h0);
    chk(rd, 32'h1400);
    chk(hresp, 1'b0);
    bus(1'b0, 32'hc, 32'h0);
    chk(rd, 32'h0);
    fcnt = $urandom;
    bus(1'b1, 32'h4, {4'h0, fcnt});
    bus(1'b0, 32'h4, 32'h0);
    chk(rd, {4'h0, fcnt});
    $display("register test done");
    frame(1, 0, FMT_UNPROTECTED, 3'h6, 3'h0, 0);
    frame(1, 1, FMT_SINGLE_CHECK, 3'h6, 3'h0, 0);
    frame(1, 0, FMT_MULTI_CHECK, 3'h2, 3'h0, 0);
    frame(1, 0, FMT_SINGLE_CHECK, 3'h6, 3'h5, 0);
    frame(1, 0, FMT_CODED, 3'h0, 3'h0, 0);
    frame(0, 0, FMT_UNPROTECTED, 3'h6, 3'h0, 0);
    frame(1, 1, FMT_UNPROTECTED, 3'h6, 3'h0, 1);
    bus(1'b0, 32'h8, 32'h0);
    chk(rd[1], 1'b1);
    bus(1'b1, 32'h8, 32'h2);
    bus(1'b0, 32'h8, 32'h0);
    chk(rd[1], 1'b0);
    $display("status test done");
    report_and_stop();
  end
  initial begin
    #2000000;
    n_errors++;
    report_and_stop();
  end
endmodule : tb_top
